/* verilog/mcc_defines.vh */
// Purpose: Shared constants for the channel/misc command handler
// Assumes: Included by bare name from every design file
// Notes:   Byte addresses of the APB registers are word aligned
//
// Function
// - Recognise exact three-byte read-enable request 0x46/0x25
// - Echo header, then one to three mask bytes
// - Wrong length gives exception 0xC6 code 03
// - Set request 0x26 applies mask bits per channel
// - Set success answers header plus zero result byte
// - Out-of-range mask or bad length gives exception
// - Read misc 0x29 echoes header plus settings byte
// - Bit7 filter 50/60 Hz, bit5 fast mode
// - Reserved settings bits read back as zero
// - Write misc 0x2A applies byte, answers zero result
// - Reserved bit set or bad length gives exception
`ifndef MCC_DEFINES_VH
`define MCC_DEFINES_VH

// ****************************************************************
// Protocol codes
// ****************************************************************
`define MCC_FUNC_VENDOR    8'h46
`define MCC_FUNC_EXCEPT    8'hc6
`define MCC_EXC_CODE       8'h03
`define MCC_SUB_RD_EN      8'h25
`define MCC_SUB_WR_EN      8'h26
`define MCC_SUB_RD_MISC    8'h29
`define MCC_SUB_WR_MISC    8'h2a
`define MCC_RESULT_OK      8'h00

// ****************************************************************
// Settings byte layout
// ****************************************************************
`define MCC_MISC_FILTER_BIT 7
`define MCC_MISC_FAST_BIT   5
`define MCC_MISC_RSVD_MASK  8'h5f

// ****************************************************************
// APB register map (byte addresses) and reset values
// ****************************************************************
`define MCC_OFS_CTRL       12'h000
`define MCC_OFS_CHMASK     12'h004
`define MCC_OFS_MISC       12'h008
`define MCC_OFS_STAT       12'h00c
`define MCC_CTRL_ADDR_LSB  0
`define MCC_CTRL_CNT_LSB   8
`define MCC_RST_STATION    8'h01
`define MCC_RST_CHCOUNT    5'h08
`define MCC_MAX_CHCOUNT    5'h18
`define MCC_RST_CHMASK     24'h0000ff
`define MCC_RST_MISC       8'h00

`endif

/* verilog/mcc_rx_collect.v */
// Purpose: Collects one request frame byte by byte
// Assumes: Framing and CRC already stripped; rx_last marks last byte
// Notes:   Keeps the first six bytes, counts length saturating at 7
`include "mcc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module mcc_rx_collect (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // Accepted byte
    input  wire        take,
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    // Collected frame
    output reg         frame_done_ff,
    output reg  [2:0]  frame_len_ff,
    output wire [47:0] frame_bytes
);

    reg [7:0] buf_mem [0:5];
    reg [2:0] cnt_ff;
    integer   i;

    // *****************************************************************
    // Byte capture
    // *****************************************************************
    // A length of 7 stands for "too long"; no request here needs more
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff        <= 3'h0;
            frame_done_ff <= 1'b0;
            frame_len_ff  <= 3'h0;
            for (i = 0; i < 6; i = i + 1) begin
                buf_mem[i] <= 8'h00;
            end
        end else begin
            frame_done_ff <= 1'b0;
            if (take) begin
                if (cnt_ff < 3'h6) begin
                    buf_mem[cnt_ff] <= rx_data;
                end
                if (rx_last) begin
                    frame_done_ff <= 1'b1;
                    frame_len_ff  <= (cnt_ff == 3'h7) ? 3'h7 : cnt_ff + 3'h1;
                    cnt_ff        <= 3'h0;
                end else if (cnt_ff != 3'h7) begin
                    cnt_ff <= cnt_ff + 3'h1;
                end
            end
        end
    end

    // Flatten the byte store, byte 0 in the low lane
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_flat
            assign frame_bytes[g*8 +: 8] = buf_mem[g];
        end
    endgenerate

endmodule
`default_nettype wire

/* verilog/mcc_tx_serial.v */
// Purpose: Sends a response of up to six bytes with valid/ready
// Assumes: Load only while not busy
// Notes:   Byte 0 of the load word goes out first
`include "mcc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module mcc_tx_serial (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // Load port
    input  wire        load,
    input  wire [2:0]  load_len,
    input  wire [47:0] load_bytes,
    // Byte stream out
    output wire        tx_valid,
    output wire [7:0]  tx_data,
    output wire        tx_last,
    input  wire        tx_ready,
    // State
    output wire        busy
);

    reg [47:0] shreg_ff;
    reg [2:0]  rem_ff;

    // *****************************************************************
    // Shift out
    // *****************************************************************
    // A shift register keeps tx_data straight from flops
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shreg_ff <= 48'h0;
            rem_ff   <= 3'h0;
        end else if (load) begin
            shreg_ff <= load_bytes;
            rem_ff   <= load_len;
        end else if (tx_valid && tx_ready) begin
            shreg_ff <= {8'h00, shreg_ff[47:8]};
            rem_ff   <= rem_ff - 3'h1;
        end
    end

    assign busy     = (rem_ff != 3'h0);
    assign tx_valid = busy;
    assign tx_data  = shreg_ff[7:0];
    assign tx_last  = (rem_ff == 3'h1);  // Handshake term, combinational

endmodule
`default_nettype wire

/* verilog/mcc_cmd_handler.v */
// Purpose: Vendor sub-functions for channel enables and misc settings
// Assumes: Frames arrive without framing or CRC, one byte per beat
// Notes:   Other addresses, functions and sub-functions get no answer
//
// The address map and the APB interface to the registers are this design's own decisions.
`include "mcc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module mcc_cmd_handler (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // Request byte stream
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    output wire        rx_ready,
    // Response byte stream
    output wire        tx_valid,
    output wire [7:0]  tx_data,
    output wire        tx_last,
    input  wire        tx_ready,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // Applied settings
    output wire [23:0] chan_en,
    output wire        filter_50hz,
    output wire        fast_mode
);

    // *****************************************************************
    // Local constants
    // *****************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_SEND = 2'h2;

    // *****************************************************************
    // Functions
    // *****************************************************************
    // Bits allowed in a mask for a given channel count
    function [23:0] valid_mask;
        input [4:0] count;
        begin
            valid_mask = ~(24'hffffff << count);
        end
    endfunction

    // Mask bytes needed to cover a given channel count
    function [2:0] mask_bytes;
        input [4:0] count;
        begin
            if (count > 5'h10) begin
                mask_bytes = 3'h3;
            end else if (count > 5'h08) begin
                mask_bytes = 3'h2;
            end else begin
                mask_bytes = 3'h1;
            end
        end
    endfunction

    // Clamp a channel count into 1..24
    function [4:0] clamp_count;
        input [7:0] v;
        begin
            if (v == 8'h00) begin
                clamp_count = 5'h01;
            end else if (v > {3'h0, `MCC_MAX_CHCOUNT}) begin
                clamp_count = `MCC_MAX_CHCOUNT;
            end else begin
                clamp_count = v[4:0];
            end
        end
    endfunction

    // *****************************************************************
    // Declarations
    // *****************************************************************
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [7:0]  station_ff;
    reg  [4:0]  chcount_ff;
    reg  [23:0] chmask_ff;
    reg  [7:0]  misc_ff;
    reg  [15:0] served_ff;
    reg  [15:0] excnt_ff;
    wire        frame_done;
    wire [2:0]  frame_len;
    wire [47:0] frame_bytes;
    wire        tx_busy;
    wire [7:0]  b_addr;
    wire [7:0]  b_func;
    wire [7:0]  b_sub;
    wire [7:0]  b3;
    wire [7:0]  b4;
    wire [7:0]  b5;
    reg         resp_load;
    reg  [2:0]  resp_len;
    reg  [47:0] resp_bytes;
    reg         set_mask;
    reg  [23:0] new_mask;
    reg         set_misc;
    reg         is_exc;
    wire [23:0] req_mask;
    wire [23:0] cur_valid;
    wire        apb_wr;
    wire        apb_rd;

    assign b_addr = frame_bytes[7:0];
    assign b_func = frame_bytes[15:8];
    assign b_sub  = frame_bytes[23:16];
    assign b3     = frame_bytes[31:24];
    assign b4     = frame_bytes[39:32];
    assign b5     = frame_bytes[47:40];

    // *****************************************************************
    // Frame collection and response sending
    // *****************************************************************
    // New bytes are refused while a frame is decoded or answered.
    // The done cycle is closed too: a byte taken there would land in
    // byte 0 of the store while the finished frame is still decoded.
    assign rx_ready = (state_ff == ST_IDLE) && !frame_done;

    mcc_rx_collect u_rx (
        .ref_clk       (ref_clk),
        .nrst          (nrst),
        .take          (rx_valid && rx_ready),
        .rx_data       (rx_data),
        .rx_last       (rx_last),
        .frame_done_ff (frame_done),
        .frame_len_ff  (frame_len),
        .frame_bytes   (frame_bytes)
    );

    mcc_tx_serial u_tx (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .load       (resp_load),
        .load_len   (resp_len),
        .load_bytes (resp_bytes),
        .tx_valid   (tx_valid),
        .tx_data    (tx_data),
        .tx_last    (tx_last),
        .tx_ready   (tx_ready),
        .busy       (tx_busy)
    );

    // *****************************************************************
    // Request decode
    // *****************************************************************
    // Missing mask bytes of a short set request count as disabled
    assign req_mask  = {(frame_len >= 3'h6) ? b5 : 8'h00,
                        (frame_len >= 3'h5) ? b4 : 8'h00, b3};
    assign cur_valid = valid_mask(chcount_ff);

    // One decision per collected frame, taken in ST_EXEC
    always @* begin
        resp_load  = 1'b0;
        resp_len   = 3'h3;
        resp_bytes = {24'h0, `MCC_EXC_CODE, `MCC_FUNC_EXCEPT, b_addr};
        set_mask   = 1'b0;
        new_mask   = req_mask;
        set_misc   = 1'b0;
        is_exc     = 1'b0;
        if (state_ff == ST_EXEC && b_addr == station_ff &&
            b_func == `MCC_FUNC_VENDOR) begin
            if (b_sub == `MCC_SUB_RD_EN) begin
                resp_load = 1'b1;
                if (frame_len != 3'h3) begin
                    is_exc = 1'b1;
                end else begin
                    // Header echo then as many bytes as channels need
                    resp_len   = 3'h3 + mask_bytes(chcount_ff);
                    resp_bytes = {chmask_ff, b_sub, b_func, b_addr};
                end
            end else if (b_sub == `MCC_SUB_WR_EN) begin
                resp_load = 1'b1;
                if (frame_len < 3'h4 || frame_len > 3'h6 ||
                    (req_mask & ~cur_valid) != 24'h0) begin
                    is_exc = 1'b1;
                end else begin
                    set_mask   = 1'b1;
                    resp_len   = 3'h4;
                    resp_bytes = {16'h0, `MCC_RESULT_OK, b_sub,
                                  b_func, b_addr};
                end
            end else if (b_sub == `MCC_SUB_RD_MISC) begin
                resp_load = 1'b1;
                if (frame_len != 3'h3) begin
                    is_exc = 1'b1;
                end else begin
                    resp_len   = 3'h4;
                    resp_bytes = {16'h0, misc_ff & ~`MCC_MISC_RSVD_MASK,
                                  b_sub, b_func, b_addr};
                end
            end else if (b_sub == `MCC_SUB_WR_MISC) begin
                resp_load = 1'b1;
                if (frame_len != 3'h4 ||
                    (b3 & `MCC_MISC_RSVD_MASK) != 8'h00) begin
                    is_exc = 1'b1;
                end else begin
                    set_misc   = 1'b1;
                    resp_len   = 3'h4;
                    resp_bytes = {16'h0, `MCC_RESULT_OK, b_sub,
                                  b_func, b_addr};
                end
            end
        end
    end

    // *****************************************************************
    // Sequencer
    // *****************************************************************
    // Wait for the sender to drain before taking the next request
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (frame_done) begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                nxt_state = resp_load ? ST_SEND : ST_IDLE;
            end
            ST_SEND: begin
                if (!tx_busy) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // *****************************************************************
    // APB slave
    // *****************************************************************
    // Zero wait states; every access completes in its access phase.
    // Read data is registered at the setup edge, so it already stands
    // when the master samples it in the access phase.
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !pwrite;

    // Applied state; a frame update wins over a same-cycle APB write
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            station_ff <= `MCC_RST_STATION;
            chcount_ff <= `MCC_RST_CHCOUNT;
            chmask_ff  <= `MCC_RST_CHMASK;
            misc_ff    <= `MCC_RST_MISC;
        end else begin
            if (apb_wr && paddr == `MCC_OFS_CTRL) begin
                station_ff <= pwdata[`MCC_CTRL_ADDR_LSB +: 8];
                chcount_ff <= clamp_count(pwdata[`MCC_CTRL_CNT_LSB +: 8]);
            end
            // Only flops written by an accepted request change
            if (set_mask) begin
                chmask_ff <= new_mask;
            end else if (apb_wr && paddr == `MCC_OFS_CHMASK) begin
                chmask_ff <= pwdata[23:0] & cur_valid;
            end
            if (set_misc) begin
                misc_ff <= b3;
            end else if (apb_wr && paddr == `MCC_OFS_MISC) begin
                misc_ff <= pwdata[7:0] & ~`MCC_MISC_RSVD_MASK;
            end
        end
    end

    // Answer counters, wrapping; both share one word so software
    // sees a consistent pair in a single read
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            served_ff <= 16'h0;
            excnt_ff  <= 16'h0;
        end else if (resp_load) begin
            if (is_exc) begin
                excnt_ff <= excnt_ff + 16'h1;
            end else begin
                served_ff <= served_ff + 16'h1;
            end
        end
    end

    // Read data and error are registered in the setup cycle
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            if (paddr == `MCC_OFS_CTRL) begin
                if (apb_rd) begin
                    prdata <= {19'h0, chcount_ff, station_ff};
                end
            end else if (paddr == `MCC_OFS_CHMASK) begin
                if (apb_rd) begin
                    prdata <= {8'h0, chmask_ff};
                end
            end else if (paddr == `MCC_OFS_MISC) begin
                if (apb_rd) begin
                    prdata <= {24'h0, misc_ff};
                end
            end else if (paddr == `MCC_OFS_STAT) begin
                if (apb_rd) begin
                    prdata <= {excnt_ff, served_ff};
                end else begin
                    pslverr <= 1'b1;   // Counters are read only
                end
            end else begin
                pslverr <= 1'b1;       // Unmapped address
            end
        end
    end

    // *****************************************************************
    // Applied settings out
    // *****************************************************************
    assign chan_en     = chmask_ff;
    assign filter_50hz = misc_ff[`MCC_MISC_FILTER_BIT];
    assign fast_mode   = misc_ff[`MCC_MISC_FAST_BIT];

endmodule
`default_nettype wire

/* verification/mcc_chk.sv */
// Purpose: Port assertions for the command handler
// Assumes: One clock, asynchronous active-low reset
// Notes:   Byte positions are rebuilt from the handshakes
`timescale 1ns/1ps
`default_nettype none
module mcc_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        nrst,
    // Link
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_last,
    input wire logic        rx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Settings
    input wire logic [23:0] chan_en,
    input wire logic        filter_50hz,
    input wire logic        fast_mode
);
    logic [2:0] rx_idx_ff;
    logic [2:0] tx_idx_ff;
    logic [7:0] sub_ff;
    logic [7:0] func_ff;
    wire        ok = tx_valid && func_ff == 8'h46;
    // Positions, since either stream may stall mid-frame
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_idx_ff <= 3'h0;
            tx_idx_ff <= 3'h0;
            sub_ff    <= 8'h00;
            func_ff   <= 8'h00;
        end else begin
            if (rx_valid && rx_ready) begin
                rx_idx_ff <= rx_last ? 3'h0 : rx_idx_ff + 3'h1;
                if (rx_idx_ff == 3'h2) sub_ff <= rx_data;
            end
            if (tx_valid && tx_ready) begin
                tx_idx_ff <= tx_last ? 3'h0 : tx_idx_ff + 3'h1;
                if (tx_idx_ff == 3'h1) func_ff <= tx_data;
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_func;
        tx_valid && tx_idx_ff == 3'h1 |-> tx_data inside {8'h46, 8'hc6};
    endproperty
    a_func: assert property (p_func) else $error("bad function byte");
    property p_exc;
        tx_valid && tx_idx_ff == 3'h2 && func_ff == 8'hc6
            |-> tx_data == 8'h03 && tx_last;
    endproperty
    a_exc: assert property (p_exc) else $error("bad exception");
    property p_sub;
        ok && tx_idx_ff == 3'h2 |-> tx_data == sub_ff && !tx_last;
    endproperty
    a_sub: assert property (p_sub) else $error("bad sub echo");
    property p_res;
        ok && tx_idx_ff == 3'h3 && sub_ff inside {8'h26, 8'h2a}
            |-> tx_data == 8'h00 && tx_last;
    endproperty
    a_res: assert property (p_res) else $error("bad result");
    property p_misc;
        ok && tx_idx_ff == 3'h3 && sub_ff == 8'h29 |-> tx_last &&
            tx_data == {filter_50hz, 1'b0, fast_mode, 5'h00};
    endproperty
    a_misc: assert property (p_misc) else $error("bad misc byte");
    property p_mask;
        ok && tx_idx_ff == 3'h3 && sub_ff == 8'h25 |-> tx_data == chan_en[7:0];
    endproperty
    a_mask: assert property (p_mask) else $error("bad mask byte");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_keep;
        !$stable({chan_en, filter_50hz, fast_mode})
            |-> !$past(rx_ready) || $past(psel && penable && pwrite);
    endproperty
    a_keep: assert property (p_keep) else $error("stray change");
    property p_apb;
        psel && !penable && !pwrite && paddr == 12'h008 |=> prdata ==
            {24'h0, $past(filter_50hz), 1'b0, $past(fast_mode), 5'h00};
    endproperty
    a_apb: assert property (p_apb) else $error("bad misc read");
    property p_err;
        psel && !penable && paddr >= 12'h010 |=> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no slave error");
    c_exc: cover property (tx_valid && func_ff == 8'hc6 && tx_last);
    c_misc: cover property (ok && sub_ff == 8'h29 && tx_last);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind mcc_cmd_handler mcc_chk u_mcc_chk (.ref_clk, .nrst, .rx_valid,
    .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .chan_en, .filter_50hz, .fast_mode);
`default_nettype wire

/* verification/mcc_host.sv */
// Purpose: Link host that sends requests and gathers answers
// Assumes: Handler takes a byte on rx_valid and rx_ready
// Notes:   Slow mode drops tx_ready every other cycle
`timescale 1ns/1ps
`default_nettype none
module mcc_host (
    // Clock
    input  wire logic       ref_clk,
    // Requests
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       rx_last,
    input  wire logic       rx_ready,
    // Responses
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_ready
);
    logic        slow = 1'b0;
    int          rcount = 0;
    logic [47:0] rsp = 48'h0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        tx_ready = 1'b0;
    end
    // Shift in each accepted response byte, first byte ends up highest
    always @(posedge ref_clk) begin
        tx_ready <= !slow || !tx_ready;
        if (tx_valid && tx_ready) begin
            rsp    <= {rsp[39:0], tx_data};
            rcount <= rcount + 1;
        end
    end
    task automatic clear();
        rcount = 0;
        rsp    = 48'h0;
    endtask
    // Frame bytes sit right-aligned in b, header first
    task automatic send(input logic [47:0] b, input int n);
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= b[8*(n-1-i) +: 8];
            rx_last  <= (i == n - 1);
            @(posedge ref_clk);
            while (rx_ready !== 1'b1) @(posedge ref_clk);
        end
        // Released line shows no stale byte
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
        rx_last  <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/tb_modbus_channel_misc_config_cmds.sv */
// Purpose: Self-checking bench for the command handler
// Assumes: Station address 1, link host model on the far side
// Notes:   Settings are driven over the link and over APB
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_channel_misc_config_cmds;
    logic        ref_clk = 1'b0, nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, e, rx_valid, rx_last, rx_ready;
    logic        tx_valid, tx_last, tx_ready, filter_50hz, fast_mode;
    logic [7:0]  rx_data, tx_data;
    logic [23:0] chan_en;
    logic [7:0]  mv [3] = '{8'h80, 8'h20, 8'ha0};
    int          n_errors = 0, samples_checked = 0;
    always #20 ref_clk = ~ref_clk;
    mcc_cmd_handler u_mcc_cmd_handler (.ref_clk, .nrst, .rx_valid,
        .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last,
        .tx_ready, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .chan_en, .filter_50hz, .fast_mode);
    mcc_host u_mcc_host (.ref_clk, .rx_valid, .rx_data, .rx_last,
        .rx_ready, .tx_valid, .tx_data, .tx_ready);
    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; pready is sampled, never assumed
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Send n request bytes, expect m answer bytes
    task automatic xact(input logic [47:0] b, input int n,
                        input logic [47:0] x, input int m);
        u_mcc_host.clear();
        u_mcc_host.send(b, n);
        for (int k = 0; k < 100 && u_mcc_host.rcount != m; k++)
            @(posedge ref_clk);
        chk(u_mcc_host.rsp, x);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        chk({24'h0, chan_en}, 48'h0000ff);
        xact(48'h014625, 3, 48'h014625ff, 4);
        xact(48'h014626a5, 4, 48'h01462600, 4);
        chk({24'h0, chan_en}, 48'h0000a5);
        xact(48'h0146260001, 5, 48'h01c603, 3);
        chk({24'h0, chan_en}, 48'h0000a5);
        xact(48'h01462500, 4, 48'h01c603, 3);
        apb(1'b1, 12'h000, 32'h0000_1801);
        xact(48'h014626112233, 6, 48'h014626000000 >> 16, 4);
        chk({24'h0, chan_en}, 48'h332211);
        u_mcc_host.slow = 1'b1;
        xact(48'h014625, 3, 48'h014625112233, 6);
        apb(1'b0, 12'h004, 32'h0);
        chk({16'h0, q}, 48'h00332211);
        foreach (mv[i]) begin
            xact({40'h01462a, mv[i]}, 4, 48'h01462a00, 4);
            chk({46'h0, filter_50hz, fast_mode},
                {46'h0, mv[i][7], mv[i][5]});
            xact(48'h014629, 3, {40'h014629, mv[i]}, 4);
        end
        xact(48'h01462a40, 4, 48'h01c603, 3);
        xact(48'h01462a01, 4, 48'h01c603, 3);
        xact(48'h01462a, 3, 48'h01c603, 3);
        chk({46'h0, filter_50hz, fast_mode}, 48'h3);
        u_mcc_host.send(48'h024625, 3);
        u_mcc_host.send(48'h014725, 3);
        xact(48'h01462900, 4, 48'h01c603, 3);
        apb(1'b1, 12'h008, 32'h0000_00ff);
        apb(1'b0, 12'h008, 32'h0);
        chk({16'h0, q}, 48'h000000a0);
        apb(1'b0, 12'h010, 32'h0);
        chk({47'h0, e}, 48'h1);
        apb(1'b1, 12'h00c, 32'h0);
        chk({47'h0, e}, 48'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk({16'h0, q}, 48'h0006000a);
        tally_and_finish();
    end
    // Whole run needs well under a tenth of this span
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
